// file: src/iwd_pkg.sv
// Purpose: constants and types for the indexed-port watchdog timer
// Assumes: 10 MHz clock, host I/O cycles arrive as one-cycle strobes on clk_i
// Notes:   register indices are the index-port values written by the host
// Functional notes
// R1: two consecutive writes of the unlock key to the index port enter configuration mode.
// R2: the host writes a register index to the index port, then reads or writes it through the data port.
// R3: writing the watchdog bank number to the bank-select register makes watchdog registers reachable.
// R4: the watchdog runs only when the activation register holds one, and is disabled after reset.
// R5: bit 3 of the unit register selects minutes when one and seconds when zero, seconds by default.
// R6: the count register holds the timeout length; zero stops the timer, 01 to FF run it.
// R7: when the count runs out before a refresh, the timeout output is raised.
// R8: any write to the count register restarts the countdown from the new value.
// R9: with bit 6 of the control register set, keyboard activity refreshes the count.
// R10: writing one to bit 5 of the control register forces a timeout and the bit clears itself.
// R11: bit 4 of the control register reads one once the watchdog has timed out.
// R12: writing the lock key to the index port leaves configuration mode.
// R13: a one-second or one-minute tick from the clock decrements a nonzero count while enabled.
// R14: while locked, data-port accesses are ignored and index writes only count as unlock key bytes.
package iwd_pkg;
    // port addresses
    localparam logic [7:0] IWD_PORT_INDEX  = 8'h2E;
    localparam logic [7:0] IWD_PORT_DATA   = 8'h2F;
    // keys and bank
    localparam logic [7:0] IWD_KEY_UNLOCK  = 8'h87;
    localparam logic [7:0] IWD_KEY_LOCK    = 8'hAA;
    localparam logic [7:0] IWD_BANK_WDT    = 8'h08;
    // register indices
    localparam logic [7:0] IWD_REG_BANK    = 8'h07;
    localparam logic [7:0] IWD_REG_ACT     = 8'h30;
    localparam logic [7:0] IWD_REG_UNIT    = 8'hF5;
    localparam logic [7:0] IWD_REG_COUNT   = 8'hF6;
    localparam logic [7:0] IWD_REG_CTRL    = 8'hF7;
    // fields
    localparam int         IWD_ACT_BIT     = 0;
    localparam int         IWD_UNIT_BIT    = 3;
    localparam int         IWD_KBD_BIT     = 6;
    localparam int         IWD_FORCE_BIT   = 5;
    localparam int         IWD_STAT_BIT    = 4;
    localparam logic [7:0] IWD_RST_BYTE    = 8'h00;
    localparam logic [7:0] IWD_BANK_RST    = 8'h00;
    // timing
    localparam int         IWD_CLK_HZ      = 10_000_000;
    localparam int         IWD_SEC_S       = 1;
    localparam int         IWD_SEC_CYC     = IWD_CLK_HZ * IWD_SEC_S;
    localparam int         IWD_MIN_S       = 60;
    localparam logic [5:0] IWD_MIN_LAST    = 6'(IWD_MIN_S - 1);

    typedef enum logic [1:0] {
        IWD_LOCKED = 2'b00,
        IWD_KEY1   = 2'b01,
        IWD_OPEN   = 2'b11
    } iwd_cfg_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } iwd_io_t;
endpackage : iwd_pkg

// file: src/iwd_watchdog.sv
// Purpose: watchdog timer behind an index/data I/O port pair with key lock
// Assumes: io_i strobes are one clk_i cycle, same clock domain
// Notes:   timeout_o stays high until the count is rewritten or timer disabled
`timescale 1ns/1ns
module iwd_watchdog
    import iwd_pkg::*;
#(
    parameter int SEC_CYC = IWD_SEC_CYC
)
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    // host i/o cycles
    input  wire iwd_io_t    io_i,
    output      logic [7:0] rdata_o,
    // keyboard activity pin
    input  wire logic       kbd_act_i,
    // timeout signal
    output      logic       timeout_o
);
    iwd_cfg_t    cfg_r,    cfg_nxt;
    logic [7:0]  index_r,  index_nxt;
    logic [7:0]  bank_r,   bank_nxt;
    logic        act_r,    act_nxt;
    logic        unit_r,   unit_nxt;
    logic [7:0]  count_r,  count_nxt;
    logic        kbd_en_r, kbd_en_nxt;
    logic        to_r,     to_nxt;
    logic [7:0]  rdata_r,  rdata_nxt;
    logic [31:0] pre_r,    pre_nxt;
    logic [5:0]  min_r,    min_nxt;
    logic        kbd_s1_r, kbd_s2_r, kbd_s3_r;
    logic        idx_wr, dat_wr, dat_rd, wdt_sel, tick_sec, tick, kbd_edge, kbd_ref;

    assign idx_wr   = io_i.wr && io_i.addr == IWD_PORT_INDEX;
    assign dat_wr   = io_i.wr && io_i.addr == IWD_PORT_DATA && cfg_r == IWD_OPEN; // [R14]
    assign dat_rd   = io_i.rd && io_i.addr == IWD_PORT_DATA && cfg_r == IWD_OPEN; // [R14]
    assign wdt_sel  = bank_r == IWD_BANK_WDT; // [R3]
    assign kbd_edge = kbd_s2_r && !kbd_s3_r;
    assign tick_sec = pre_r == 32'(SEC_CYC - 1);
    assign tick     = tick_sec && (!unit_r || min_r == IWD_MIN_LAST); // [R13]
    assign kbd_ref  = kbd_en_r && kbd_edge && act_r && count_r != 8'h00; // [R9]

    // keyboard pin synchroniser
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            kbd_s1_r <= 1'b0;
            kbd_s2_r <= 1'b0;
            kbd_s3_r <= 1'b0;
        end
        else
        begin
            kbd_s1_r <= kbd_act_i;
            kbd_s2_r <= kbd_s1_r;
            kbd_s3_r <= kbd_s2_r;
        end
    end

    // key lock state
    always_comb
    begin
        cfg_nxt = cfg_r;
        if (idx_wr)
        begin
            case (cfg_r)
                IWD_LOCKED: cfg_nxt = (io_i.wdata == IWD_KEY_UNLOCK) ? IWD_KEY1 : IWD_LOCKED; // [R1]
                IWD_KEY1:   cfg_nxt = (io_i.wdata == IWD_KEY_UNLOCK) ? IWD_OPEN : IWD_LOCKED; // [R1]
                IWD_OPEN:   cfg_nxt = (io_i.wdata == IWD_KEY_LOCK) ? IWD_LOCKED : IWD_OPEN;   // [R12]
                default:    cfg_nxt = IWD_LOCKED;
            endcase
        end
    end

    // register file and countdown
    always_comb
    begin
        index_nxt  = index_r;
        bank_nxt   = bank_r;
        act_nxt    = act_r;
        unit_nxt   = unit_r;
        count_nxt  = count_r;
        kbd_en_nxt = kbd_en_r;
        to_nxt     = to_r;
        rdata_nxt  = rdata_r;
        pre_nxt    = tick_sec ? 32'h0 : pre_r + 32'h1;
        min_nxt    = (tick_sec && unit_r) ? ((min_r == IWD_MIN_LAST) ? 6'h0 : min_r + 6'h1) : min_r;
        if (act_r && count_r != 8'h00 && tick) // [R13]
        begin
            count_nxt = count_r - 8'h01;
            if (count_r == 8'h01)
                to_nxt = 1'b1; // [R7]
        end
        // refresh outranks a tick in the same cycle, timeout included
        if (kbd_ref) // [R9]
        begin
            count_nxt = count_r;
            to_nxt    = to_r;
            pre_nxt   = 32'h0;
            min_nxt   = 6'h0;
        end
        if (idx_wr && cfg_r == IWD_OPEN)
            index_nxt = io_i.wdata; // [R2]
        if (dat_wr)
        begin
            if (index_r == IWD_REG_BANK)
                bank_nxt = io_i.wdata; // [R3]
            else if (wdt_sel)
            begin
                case (index_r)
                    IWD_REG_ACT:  act_nxt = io_i.wdata == 8'h01; // [R4]
                    IWD_REG_UNIT: unit_nxt = io_i.wdata[IWD_UNIT_BIT]; // [R5]
                    IWD_REG_COUNT:
                    begin
                        count_nxt = io_i.wdata; // [R8]
                        to_nxt    = 1'b0;
                        pre_nxt   = 32'h0;
                        min_nxt   = 6'h0;
                    end
                    IWD_REG_CTRL:
                    begin
                        kbd_en_nxt = io_i.wdata[IWD_KBD_BIT]; // [R9]
                        if (io_i.wdata[IWD_FORCE_BIT])
                            to_nxt = 1'b1; // [R10]
                    end
                    default: ;
                endcase
            end
        end
        if (dat_rd)
        begin
            rdata_nxt = IWD_RST_BYTE;
            if (wdt_sel)
            begin
                case (index_r)
                    IWD_REG_ACT:   rdata_nxt = {7'h00, act_r};
                    IWD_REG_UNIT:  rdata_nxt = {4'h0, unit_r, 3'h0};
                    IWD_REG_COUNT: rdata_nxt = count_r;
                    IWD_REG_CTRL:  rdata_nxt = {1'b0, kbd_en_r, 1'b0, to_r, 4'h0}; // [R11] [R10]
                    default:       rdata_nxt = IWD_RST_BYTE;
                endcase
            end
        end
        if (!act_nxt)
            to_nxt = 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            cfg_r    <= IWD_LOCKED;
            index_r  <= IWD_RST_BYTE;
            bank_r   <= IWD_BANK_RST;
            act_r    <= 1'b0; // [R4]
            unit_r   <= 1'b0; // [R5]
            count_r  <= IWD_RST_BYTE; // [R6]
            kbd_en_r <= 1'b0;
            to_r     <= 1'b0;
            rdata_r  <= IWD_RST_BYTE;
            pre_r    <= 32'h0;
            min_r    <= 6'h0;
        end
        else
        begin
            cfg_r    <= cfg_nxt;
            index_r  <= index_nxt;
            bank_r   <= bank_nxt;
            act_r    <= act_nxt;
            unit_r   <= unit_nxt;
            count_r  <= count_nxt;
            kbd_en_r <= kbd_en_nxt;
            to_r     <= to_nxt;
            rdata_r  <= rdata_nxt;
            pre_r    <= pre_nxt;
            min_r    <= min_nxt;
        end
    end

    assign rdata_o   = rdata_r;
    assign timeout_o = to_r; // [R7]

    sequence s_unlock2;
        idx_wr && io_i.wdata == IWD_KEY_UNLOCK && cfg_r == IWD_KEY1;
    endsequence

    AST_UNLOCK: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R1]
        s_unlock2 |=> cfg_r == IWD_OPEN) else $error("unlock failed");
    AST_LOCK: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R12]
        idx_wr && cfg_r == IWD_OPEN && io_i.wdata == IWD_KEY_LOCK |=> cfg_r == IWD_LOCKED)
        else $error("lock failed");
    AST_LOCKED_IGNORE: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R14]
        io_i.wr && io_i.addr == IWD_PORT_DATA && cfg_r != IWD_OPEN |=> $stable(count_r) || $past(tick))
        else $error("locked write took effect");
    AST_INDEX: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R2]
        idx_wr && cfg_r == IWD_OPEN |=> index_r == $past(io_i.wdata)) else $error("index not stored");
    AST_REFRESH: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R8]
        dat_wr && wdt_sel && index_r == IWD_REG_COUNT |=> count_r == $past(io_i.wdata) && !timeout_o)
        else $error("count reload failed");
    AST_FORCE: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R10]
        dat_wr && wdt_sel && index_r == IWD_REG_CTRL && io_i.wdata[IWD_FORCE_BIT] && act_r
        |=> timeout_o) else $error("forced timeout missing");
    AST_EXPIRE: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R7]
        act_r && tick && count_r == 8'h01 && !dat_wr && !kbd_ref |=> timeout_o) else $error("expiry missed");
    AST_DISABLED: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R4]
        !act_r |-> !timeout_o) else $error("timeout while disabled");
    AST_STATUS: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R11]
        dat_rd && wdt_sel && index_r == IWD_REG_CTRL |=> rdata_o[IWD_STAT_BIT] == $past(to_r))
        else $error("status bit wrong");

    sequence s_kbd_refresh;
        kbd_ref && !dat_wr;
    endsequence

    AST_KBD_KEEP: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R9]
        s_kbd_refresh |=> $stable(count_r) && pre_r == 32'h0) else $error("keyboard refresh lost");
    AST_DECREMENT: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R13]
        act_r && tick && count_r != 8'h00 && !dat_wr && !kbd_ref |=> count_r == $past(count_r) - 8'h01)
        else $error("count not decremented");
    AST_STOPPED: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R6]
        count_r == 8'h00 && !dat_wr |=> count_r == 8'h00) else $error("stopped count moved");
    AST_ACT_VALUE: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R4]
        dat_wr && wdt_sel && index_r == IWD_REG_ACT |=> act_r == ($past(io_i.wdata) == 8'h01))
        else $error("activation value wrong");
    AST_LOCKED_READ: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R14]
        io_i.rd && io_i.addr == IWD_PORT_DATA && cfg_r != IWD_OPEN |=> $stable(rdata_o))
        else $error("locked read took effect");
endmodule : iwd_watchdog

// file: tb/iwd_host.sv
// Purpose: host model issuing index/data port cycles
// Assumes: strobes launched at the falling edge
// Notes:   released lines carry inverted values
`timescale 1ns/1ns
module iwd_host
    import iwd_pkg::*;
(
    // clock
    input  wire logic       clk_i,
    // port cycles
    output      iwd_io_t    io_o,
    input  wire logic [7:0] rdata_i
);
    initial io_o = '0;
    task automatic cyc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(negedge clk_i);
        io_o = '{w, !w, a, d};
        @(negedge clk_i);
        io_o = '{1'b0, 1'b0, ~a, ~d};
        @(negedge clk_i);
        q = rdata_i;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        cyc(1'b1, a, d, q);
    endtask : wr
    task automatic wreg(input logic [7:0] i, input logic [7:0] d);
        wr(IWD_PORT_INDEX, i);
        wr(IWD_PORT_DATA, d);
    endtask : wreg
    task automatic rreg(input logic [7:0] i, output logic [7:0] q);
        wr(IWD_PORT_INDEX, i);
        cyc(1'b0, IWD_PORT_DATA, 8'h00, q);
    endtask : rreg
    task automatic unlock();
        wr(IWD_PORT_INDEX, IWD_KEY_UNLOCK);
        wr(IWD_PORT_INDEX, IWD_KEY_UNLOCK);
    endtask : unlock
    task automatic lock();
        wr(IWD_PORT_INDEX, IWD_KEY_LOCK);
    endtask : lock
endmodule : iwd_host

// file: tb/testbench.sv
// Purpose: self-checking bench for the indexed-port watchdog
// Assumes: short second of SC cycles
// Notes:   expiry checked a few cycles either side
`timescale 1ns/1ns
module testbench
    import iwd_pkg::*;
;
    localparam int SC = 20;
    logic        clk_i     = 1'b0;
    logic        rst_b_i   = 1'b0;
    logic        kbd_act_i = 1'b0;
    iwd_io_t     io;
    logic [7:0]  rdata_o;
    logic        timeout_o;
    logic [7:0]  to8;
    logic [7:0]  q;
    logic [31:0] lfsr      = 32'h78202050;
    int          c;
    int          m_unit    = 1;
    int          err_total = 0;
    int          n_checks  = 0;
    // reference model state
    int          md_key    = 0;
    int          md_idx    = 0;
    int          md_bank   = 0;
    int          md_act    = 0;
    int          md_unit   = 0;
    int          md_kbd    = 0;
    int          md_cnt    = 0;
    int          md_to     = 0;
    int          md_pre    = 0;
    int          md_last   = 0;
    int          md_rd[$];
    logic        md_kprev  = 1'b0;
    assign to8 = {7'h00, timeout_o};
    always #50 clk_i = ~clk_i;
    iwd_watchdog #(.SEC_CYC(SC)) DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .io_i(io), .rdata_o(rdata_o),
                                      .kbd_act_i(kbd_act_i), .timeout_o(timeout_o));
    iwd_host host (.clk_i(clk_i), .io_o(io), .rdata_i(rdata_o));
    // reference model fed by the port cycles and the keyboard pin
    initial
    forever
    begin
        @(posedge clk_i);
        if (!rst_b_i)
        begin
            md_key  = 0;
            md_idx  = 0;
            md_bank = 0;
            md_act  = 0;
            md_unit = 0;
            md_kbd  = 0;
            md_cnt  = 0;
            md_to   = 0;
            md_pre  = 0;
            md_last = 0;
        end
        else
        begin
            if (io.rd && io.addr == IWD_PORT_DATA)
            begin
                if (md_key == 2)
                begin
                    md_last = 0;
                    if (md_bank == int'(IWD_BANK_WDT))
                    begin
                        if (md_idx == int'(IWD_REG_ACT))
                            md_last = md_act;
                        else if (md_idx == int'(IWD_REG_UNIT))
                            md_last = md_unit << IWD_UNIT_BIT;
                        else if (md_idx == int'(IWD_REG_COUNT))
                            md_last = md_cnt;
                        else if (md_idx == int'(IWD_REG_CTRL))
                            md_last = (md_kbd << IWD_KBD_BIT) + (md_to << IWD_STAT_BIT);
                    end
                end
                md_rd.push_back(md_last);
            end
            md_pre++;
            if (md_kbd != 0 && kbd_act_i && !md_kprev && md_act != 0 && md_cnt > 0)
                md_pre = 0;
            if (md_pre >= SC * ((md_unit != 0) ? IWD_MIN_S : IWD_SEC_S))
            begin
                md_pre = 0;
                if (md_act != 0 && md_cnt > 0)
                begin
                    md_cnt--;
                    if (md_cnt == 0)
                        md_to = 1;
                end
            end
            md_kprev = kbd_act_i;
            if (io.wr && io.addr == IWD_PORT_INDEX)
            begin
                if (md_key == 2)
                begin
                    md_idx = int'(io.wdata);
                    if (io.wdata == IWD_KEY_LOCK)
                        md_key = 0;
                end
                else
                    md_key = (io.wdata == IWD_KEY_UNLOCK) ? md_key + 1 : 0;
            end
            if (io.wr && io.addr == IWD_PORT_DATA && md_key == 2)
            begin
                if (md_idx == int'(IWD_REG_BANK))
                    md_bank = int'(io.wdata);
                else if (md_bank == int'(IWD_BANK_WDT))
                begin
                    if (md_idx == int'(IWD_REG_ACT))
                        md_act = int'(io.wdata == 8'h01);
                    else if (md_idx == int'(IWD_REG_UNIT))
                        md_unit = int'(io.wdata[IWD_UNIT_BIT]);
                    else if (md_idx == int'(IWD_REG_COUNT))
                    begin
                        md_cnt = int'(io.wdata);
                        md_to  = 0;
                        md_pre = 0;
                    end
                    else if (md_idx == int'(IWD_REG_CTRL))
                    begin
                        md_kbd = int'(io.wdata[IWD_KBD_BIT]);
                        if (io.wdata[IWD_FORCE_BIT])
                            md_to = 1;
                    end
                end
            end
            if (md_act == 0)
                md_to = 0;
        end
    end
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt
    // expected byte of the oldest read the model has seen
    function automatic logic [7:0] exp_rd();
        return 8'(md_rd.pop_front());
    endfunction : exp_rd
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc_n(input int n);
        repeat (n) @(negedge clk_i);
    endtask : cyc_n
    // waits out c units, low just before expiry and high just after
    task automatic run(input int c);
        cyc_n(c * m_unit * SC - 5);
        chk(to8, 8'h00);
        chk(to8, 8'(md_to));
        cyc_n(10);
        chk(to8, 8'h01);
        chk(to8, 8'(md_to));
    endtask : run
    task automatic end_of_test();
        if (err_total == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    initial
    begin
        #5000000;
        err_total++;
        end_of_test();
    end
    initial
    begin
        repeat (16) @(negedge clk_i);
        rst_b_i = 1'b1;
        chk(to8, 8'(md_to));
        host.cyc(1'b0, IWD_PORT_DATA, 8'h00, q);
        chk(q, exp_rd());
        host.unlock();
        host.wreg(IWD_REG_BANK, IWD_BANK_WDT);
        host.wreg(IWD_REG_ACT, 8'h01);
        host.rreg(IWD_REG_UNIT, q);
        chk(q, exp_rd());
        host.rreg(IWD_REG_CTRL, q);
        chk(q, exp_rd());
        host.lock();
        host.wr(IWD_PORT_INDEX, IWD_KEY_UNLOCK);
        host.wr(IWD_PORT_INDEX, 8'h55);
        host.wr(IWD_PORT_INDEX, IWD_KEY_UNLOCK);
        host.wreg(IWD_REG_CTRL, 8'h20);
        chk(to8, 8'(md_to));
        host.unlock();
        host.wreg(IWD_REG_CTRL, 8'h20);
        chk(to8, 8'(md_to));
        host.rreg(IWD_REG_CTRL, q);
        chk(q, exp_rd());
        lfsr = nxt(lfsr);
        c = int'(lfsr % 3) + 1;
        host.wreg(IWD_REG_COUNT, 8'(c));
        chk(to8, 8'(md_to));
        run(c);
        host.rreg(IWD_REG_CTRL, q);
        chk(q, exp_rd());
        host.wreg(IWD_REG_COUNT, 8'h02);
        cyc_n(30);
        host.wreg(IWD_REG_COUNT, 8'h02);
        run(2);
        host.wreg(IWD_REG_COUNT, 8'h00);
        cyc_n(100);
        chk(to8, 8'(md_to));
        for (int en = 1; en >= 0; en--)
        begin
            host.wreg(IWD_REG_CTRL, (en != 0) ? 8'h40 : 8'h00);
            host.wreg(IWD_REG_COUNT, 8'h01);
            repeat (8)
            begin
                lfsr = nxt(lfsr);
                kbd_act_i = 1'b1;
                cyc_n(2 + int'(lfsr[1:0]));
                kbd_act_i = 1'b0;
                cyc_n(6);
            end
            chk(to8, 8'(md_to));
        end
        host.wreg(IWD_REG_ACT, 8'h00);
        chk(to8, 8'(md_to));
        host.wreg(IWD_REG_COUNT, 8'h01);
        cyc_n(40);
        chk(to8, 8'(md_to));
        host.wreg(IWD_REG_COUNT, 8'h00);
        host.wreg(IWD_REG_ACT, 8'h01);
        host.wreg(IWD_REG_UNIT, 8'h08);
        host.rreg(IWD_REG_UNIT, q);
        chk(q, exp_rd());
        m_unit = IWD_MIN_S;
        host.wreg(IWD_REG_COUNT, 8'h01);
        run(1);
        host.lock();
        host.wreg(IWD_REG_COUNT, 8'h00);
        chk(to8, 8'(md_to));
        host.cyc(1'b0, IWD_PORT_DATA, 8'h00, q);
        chk(q, exp_rd());
        end_of_test();
    end
endmodule : testbench
